// ===== sim/flash_host_model.sv
// host controller model: frames, msb-first bytes, mode 0 link clock
// assumes the bench clock; one link bit lasts 16 system cycles
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  input wire logic clock,  // system clock
  input wire logic dout,   // device data out
  output logic sclk,       // link clock, still between frames
  output logic csN,        // chip select, active low
  output logic din         // host data out
);
  // ------------------------------------------------------------
  // framing tasks
  // ------------------------------------------------------------
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    din = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic open_frame();
    cyc(4);
    csN <= 1'b0;
  endtask
  // data set on fall, device samples on the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      cyc(1);
      sclk <= 1'b0;
      din <= tx[i];
      cyc(8);
      sclk <= 1'b1;
      rx[i] = dout;
      cyc(7);
    end
  endtask
  // select rises after the last bit; released line toggles
  task automatic close_frame();
    cyc(1);
    sclk <= 1'b0;
    cyc(8);
    csN <= 1'b1;
    din <= ~din;
    cyc(6);
  endtask
endmodule // flash_host_model
`default_nettype wire

// ===== sim/flash_suspend_otp_tb.sv
// bench for the suspend/resume and otp sequencer over the serial link
// assumes the host model for framing and shortened latencies
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, e); end end
module flash_suspend_otp_tb import flash_sr_pkg::*; ;
  logic clock, nrst, sclk, csN, din, dout, doutEn, wip, wel;
  logic aStart, aErase, rReq, rInd;
  logic [SEC_W-1:0] aSec, rSec;
  logic [CNT_W-1:0] aCyc;
  logic [7:0] fsr, rx;
  logic [7:0] pat [4] = '{8'h12, 8'h34, 8'h56, 8'hA5};
  logic [7:0] got [4];
  int fails = 0;
  int cmp_count = 0;
  // ----------------------------------------------------------------
  // clock, design, host
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // short counts keep the run brief; expectations follow them
  flash_suspend_otp #(.OTP_CYC(50), .LAT_CYC(20)) DUT (
    .clock(clock), .nrst(nrst), .sclkPin(sclk), .chipSelN(csN),
    .serialInputLine(din), .serialOutputLine(dout),
    .serialOutputEn(doutEn), .arrayStart(aStart), .arrayErase(aErase),
    .arraySector(aSec), .arrayCycles(aCyc), .readReq(rReq),
    .readSector(rSec), .readIndeterminate(rInd), .writeInProgress(wip),
    .writeEnableLatch(wel), .flagStatus(fsr)
  );
  flash_host_model host (
    .clock(clock), .dout(dout), .sclk(sclk), .csN(csN), .din(din)
  );
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clock);
    nrst <= 1'b0;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
  endtask
  task automatic cmd(input logic [7:0] op);
    host.open_frame();
    host.xfer(op, rx);
    host.close_frame();
  endtask
  // a stuck busy flag must not hang the run
  task automatic wait_ready();
    int n;
    n = 0;
    while (fsr[7] !== 1'b1 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    if (n == 3000) begin
      fails++;
      summarize();
    end
  endtask
  task automatic start_op(input logic e, input logic [7:0] s, input int c);
    aErase <= e;
    aSec <= s;
    aCyc <= CNT_W'(c);
    aStart <= 1'b1;
    @(posedge clock);
    aStart <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  // code, three address bytes, a dummy byte on reads, then n bytes
  task automatic otp(input logic [7:0] op, input logic [7:0] a, input int n);
    host.open_frame();
    host.xfer(op, rx);
    host.xfer(8'h00, rx);
    host.xfer(8'h00, rx);
    host.xfer(a, rx);
    if (op == OP_RDOTP) host.xfer(8'h00, rx);
    for (int i = 0; i < n; i++) host.xfer(pat[i], got[i]);
    host.close_frame();
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    aStart = 1'b0;
    aErase = 1'b0;
    aSec = '0;
    aCyc = 24'h1;
    rReq = 1'b0;
    rSec = '0;
    do_reset();
    `CHK({fsr, wip, wel}, 10'h200)
    cmd(OP_SUSP);
    cmd(OP_RESUME);
    `CHK({fsr, wip}, 9'h100)
    start_op(1'b1, 8'h01, 1000);
    cmd(OP_SUSP);
    `CHK(fsr[6], 1'b1)
    wait_ready();
    `CHK(wip, 1'b0)
    start_op(1'b0, 8'h01, 100);
    `CHK({fsr, wel}, 9'h1A0)
    start_op(1'b0, 8'h02, 1000);
    cmd(OP_SUSP);
    wait_ready();
    host.open_frame();
    host.xfer(OP_RDFSR, rx);
    host.xfer(8'h00, rx);
    host.close_frame();
    `CHK(rx, 8'hD4)
    for (int i = 1; i <= 3; i++) begin
      rSec <= 8'(i);
      rReq <= 1'b1;
      @(posedge clock);
      rReq <= 1'b0;
      repeat (3) @(posedge clock);
      `CHK(rInd, i < 3)
    end
    cmd(OP_RESUME);
    `CHK({fsr, wip}, 9'h0A1)
    wait_ready();
    `CHK(fsr, 8'hD0)
    cmd(OP_RESUME);
    `CHK({fsr, wip}, 9'h021)
    wait_ready();
    `CHK(fsr, 8'h90)
    // suspend lands with less left than the latency
    host.open_frame();
    host.xfer(OP_SUSP, rx);
    start_op(1'b0, 8'h05, 24);
    host.close_frame();
    repeat (20) @(posedge clock);
    `CHK({fsr, wip}, 9'h120)
    do_reset();
    otp(OP_PGOTP, 8'h3E, 4);
    `CHK({fsr, wip, wel}, 10'h200)
    cmd(OP_WREN);
    otp(OP_PGOTP, 8'h3E, 4);
    `CHK({fsr[7], wip}, 2'b01)
    repeat (60) @(posedge clock);
    `CHK({fsr, wip, wel}, 10'h200)
    otp(OP_RDOTP, 8'h3E, 4);
    `CHK(doutEn, 1'b0)
    for (int i = 0; i < 4; i++) `CHK(got[i], pat[i < 3 ? i : 2])
    cmd(OP_WREN);
    otp(OP_PGOTP, 8'h00, 1);
    `CHK({fsr, wip, wel}, 10'h249)
    otp(OP_RDOTP, 8'h00, 1);
    `CHK(got[0], 8'hFF)
    summarize();
  end
endmodule // flash_suspend_otp_tb
`default_nettype wire

// ===== src/flash_countdown.sv
// loadable down counter for self-timed operations and latencies
// assumes a load value of at least one; done pulses once per run
`timescale 1ns/1ps
`default_nettype none
module flash_countdown #(
  parameter int W = 16  // counter width
) (
  input wire logic clock,          // system clock
  input wire logic nrst,           // async reset, active low
  input wire logic load,           // load pulse
  input wire logic [W-1:0] loadVal,  // cycles to run
  input wire logic run,            // count enable
  output logic [W-1:0] remain,     // cycles left
  output logic done                // one-cycle pulse at end
);
  logic [W-1:0] cnt_q, cnt_d;
  logic done_q, done_d;

  // freezing run keeps the count; a suspend holds by saving remain for a later reload
  always_comb begin
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (load) begin
      cnt_d = loadVal;
    end else if (run && cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
      done_d = (cnt_q == W'(1));
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign remain = cnt_q;
  assign done = done_q;
endmodule  // flash_countdown
`default_nettype wire

// ===== src/flash_link_sync.sv
// two-stage synchroniser and edge finder for the serial link pins
// assumes link clock slow enough that each level lasts several cycles
`timescale 1ns/1ps
`default_nettype none
module flash_link_sync import flash_sr_pkg::*; (
  input wire logic clock,     // system clock
  input wire logic nrst,      // async reset, active low
  input wire logic sclkPin,   // serial link clock pin
  input wire logic chipSelN,  // chip select pin, active low
  input wire logic dinPin,    // serial input line pin
  output var link_s link      // synchronised link events
);
  logic [2:0] meta_q, meta_d, sync_q, sync_d, prev_q, prev_d;

  // first stage feeds only the second one
  always_comb begin
    meta_d = {sclkPin, chipSelN, dinPin};
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_q <= LINK_IDLE;
      sync_q <= LINK_IDLE;
      prev_q <= LINK_IDLE;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // edges come from the second stage against its own history
  always_comb begin
    link.sclkRise = sync_q[2] & ~prev_q[2];
    link.sclkFall = ~sync_q[2] & prev_q[2];
    link.csActive = ~sync_q[1];
    link.csRise = sync_q[1] & ~prev_q[1];
    link.din = sync_q[0];
  end
endmodule  // flash_link_sync
`default_nettype wire

// ===== src/flash_sr_pkg.sv
// constants, states and carriers of the suspend/resume and otp sequencer
// assumes a 100 MHz system clock that samples the serial link pins
package flash_sr_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int OTP_PROG_US = 200;  // otp_program_duration
  localparam int SUSP_LAT_US = 20;   // suspend latency
  localparam int OTP_PROG_CYC = OTP_PROG_US * CLK_MHZ;
  localparam int SUSP_LAT_CYC = SUSP_LAT_US * CLK_MHZ;

  // ------------------------------------------------------------------
  // command codes and framing
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_RDFSR = 8'h70;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_RDOTP = 8'h4B;
  localparam logic [7:0] OP_PGOTP = 8'h42;
  localparam logic [1:0] ADDR_LAST = 2'h2;  // three address bytes

  // ------------------------------------------------------------------
  // flag status fields, otp layout, widths, reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] FSR_RESET = 8'h80;
  localparam int FSR_READY = 7;
  localparam int FSR_ESUSP = 6;
  localparam int FSR_PFAIL = 4;
  localparam int FSR_PSUSP = 2;
  localparam int FSR_PROT = 1;
  localparam int OTP_BYTES = 65;
  localparam logic [6:0] OTP_LAST = 7'h40;
  localparam int OTP_LOCK_BIT = 0;
  localparam logic [7:0] OTP_ERASED = 8'hFF;
  localparam int SEC_W = 8;
  localparam int CNT_W = 24;
  localparam logic [2:0] LINK_IDLE = 3'h2;  // {clock, select, data}

  typedef enum {ST_CMD, ST_HELD, ST_ADDR, ST_DUMMY, ST_OUT, ST_FSR,
                ST_WDATA, ST_SKIP} ser_e;

  typedef struct packed {
    logic sclkRise;
    logic sclkFall;
    logic csActive;
    logic csRise;
    logic din;
  } link_s;

  typedef struct packed {
    logic act;
    logic actE;
    logic fin;
    logic susp;
    logic pS;
    logic eS;
    logic flP;
    logic flE;
    logic fail;
    logic prot;
    logic wel;
    logic otpB;
    logic rdInd;
    logic [SEC_W-1:0] actSec;
    logic [SEC_W-1:0] pSec;
    logic [SEC_W-1:0] eSec;
    logic [CNT_W-1:0] pRem;
    logic [CNT_W-1:0] eRem;
  } arr_s;

  localparam arr_s ARR_RESET = '0;

endpackage

// ===== src/flash_suspend_otp.sv
// serial flash sequencer: program/erase suspend and resume, otp area
// assumes link pins from outside; array ops are started from ports
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - suspending a program sets flag bit 2
// - suspending an erase sets flag bit 6
// - ready bit 7 rises after latency; host trusts it once read
// - op nearer done than latency finishes and clears its flag
// - suspend state volatile; flag status resets to 80h
// - one nest: program inside erase suspend, resumed last-in first
// - program suspended: reads elsewhere fine, suspended sector junk
// - erase suspended: other sectors usable, suspended sector junk
// - program to erase-suspended sector ignored, bit 4 set, latch kept
// - resumed erase does not recheck lock bits
// - accepted resume: busy bit high, ready bit low while running
// - resume ignored when nothing is suspended
// - resumed op finishing sets ready bit again
// - otp read code, address, dummy; device samples on rising clock
// - otp read data out on falling clock, address steps per byte
// - otp read address sticks at 0x40, no wrap
// - raising select ends otp read at once
// - otp program without write enable ignored, flags untouched
// - otp program starts on select rise, busy bit held
// - at most 65 bytes stored, further bytes dropped
// - otp program end clears write enable and busy
// - locked otp: program ignored, latch kept, bits 1 and 4 set
module flash_suspend_otp import flash_sr_pkg::*; #(
  parameter int OTP_CYC = OTP_PROG_CYC,  // otp program time, cycles
  parameter int LAT_CYC = SUSP_LAT_CYC   // suspend latency, cycles
) (
  input wire logic clock,                    // 100 MHz system clock
  input wire logic nrst,                     // async reset, active low
  input wire logic sclkPin,                  // serial link clock pin
  input wire logic chipSelN,                 // chip select, active low
  input wire logic serialInputLine,          // serial data in
  output logic serialOutputLine,             // serial data out
  output logic serialOutputEn,               // output line driven
  input wire logic arrayStart,               // start array op pulse
  input wire logic arrayErase,               // op is erase, else program
  input wire logic [SEC_W-1:0] arraySector,  // target sector
  input wire logic [CNT_W-1:0] arrayCycles,  // op duration, cycles
  input wire logic readReq,                  // array read check pulse
  input wire logic [SEC_W-1:0] readSector,   // sector of that read
  output logic readIndeterminate,            // last read hits suspend
  output logic writeInProgress,              // status busy bit
  output logic writeEnableLatch,             // status write enable
  output logic [7:0] flagStatus              // flag status register
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  link_s link;
  arr_s a_q, a_d;
  ser_e st_q, st_d;
  logic [7:0] sh_q, sh_d, cmd_q, cmd_d, tx_q, tx_d, pd_q [OTP_BYTES];
  logic [7:0] otp_q [OTP_BYTES], otp_d [OTP_BYTES], pd_d [OTP_BYTES];
  logic [OTP_BYTES-1:0] pm_q, pm_d;
  logic [2:0] bit_q, bit_d, txc_q, txc_d;
  logic [1:0] ab_q, ab_d;
  logic [23:0] adr_q, adr_d;
  logic [6:0] ptr_q, ptr_d;
  logic so_q, so_d, oe_q, oe_d, got_q, got_d, rstSeen_q;
  logic doWren, doSusp, doRes, otpStart, otpLock, progBlock;
  logic opLoad, latLoad, suspOk, resumeOk, opDone, latDone, otpDone;
  logic [CNT_W-1:0] opVal, opRemain;

  // clamp an otp address to the last location, never wrapping
  function automatic logic [6:0] clampPtr(input logic [23:0] a);
    return (a > {17'h0, OTP_LAST}) ? OTP_LAST : a[6:0];
  endfunction

  flash_link_sync syncIn (.clock(clock), .nrst(nrst), .sclkPin(sclkPin),
    .chipSelN(chipSelN), .dinPin(serialInputLine), .link(link));

  flash_countdown #(.W(CNT_W)) opTmr (.clock(clock), .nrst(nrst),
    .load(opLoad), .loadVal(opVal), .run(a_q.act), .remain(opRemain),
    .done(opDone));

  flash_countdown #(.W(CNT_W)) latTmr (.clock(clock), .nrst(nrst),
    .load(latLoad), .loadVal(CNT_W'(LAT_CYC)), .run(a_q.susp),
    .remain(), .done(latDone));

  flash_countdown #(.W(CNT_W)) otpTmr (.clock(clock), .nrst(nrst),
    .load(otpStart), .loadVal(CNT_W'(OTP_CYC)), .run(a_q.otpB),
    .remain(), .done(otpDone));

  // ------------------------------------------------------------------
  // array operations, suspend, resume and flags
  // ------------------------------------------------------------------
  always_comb begin
    a_d = a_q;
    opLoad = 1'b0;
    opVal = arrayCycles;
    latLoad = 1'b0;
    progBlock = 1'b0;
    suspOk = 1'b0;
    resumeOk = 1'b0;
    if (readReq) begin
      a_d.rdInd = (a_q.pS && readSector == a_q.pSec) ||
                  (a_q.eS && readSector == a_q.eSec);
    end
    if (arrayStart && !a_q.act && !a_q.otpB) begin
      if (!arrayErase && a_q.eS && arraySector == a_q.eSec) begin
        progBlock = 1'b1;
        a_d.fail = 1'b1;
      end else if (!a_q.pS && !(arrayErase && a_q.eS)) begin
        a_d.act = 1'b1;
        a_d.actE = arrayErase;
        a_d.actSec = arraySector;
        opLoad = 1'b1;
      end
    end
    // suspend only while an op runs
    if (doSusp && a_q.act && !a_q.susp && !a_q.fin && !opDone) begin
      suspOk = 1'b1;
      if (a_q.actE) a_d.flE = 1'b1;
      else a_d.flP = 1'b1;
      // too close to the end to stop
      // the op timer keeps running through the latency, one cycle more
      if (opRemain <= CNT_W'(LAT_CYC + 1)) a_d.fin = 1'b1;
      else begin
        a_d.susp = 1'b1;
        latLoad = 1'b1;
      end
    end
    // latency over, park the op and show ready
    if (latDone) begin
      a_d.susp = 1'b0;
      a_d.act = 1'b0;
      if (a_q.actE) begin
        a_d.eS = 1'b1;
        a_d.eRem = opRemain;
        a_d.eSec = a_q.actSec;
      end else begin
        a_d.pS = 1'b1;
        a_d.pRem = opRemain;
        a_d.pSec = a_q.actSec;
      end
    end
    // completion restores ready, drops a pending flag
    if (opDone) begin
      a_d.act = 1'b0;
      a_d.fin = 1'b0;
      if (a_q.fin && a_q.actE) a_d.flE = 1'b0;
      if (a_q.fin && !a_q.actE) a_d.flP = 1'b0;
    end
    // resume newest first, lock bits not rechecked
    if (doRes && !a_q.act && !a_q.otpB && (a_q.pS || a_q.eS)) begin
      resumeOk = 1'b1;
      opLoad = 1'b1;
      a_d.act = 1'b1;
      if (a_q.pS) begin
        a_d.pS = 1'b0;
        a_d.flP = 1'b0;
        a_d.actE = 1'b0;
        a_d.actSec = a_q.pSec;
        opVal = a_q.pRem;
      end else begin
        a_d.eS = 1'b0;
        a_d.flE = 1'b0;
        a_d.actE = 1'b1;
        a_d.actSec = a_q.eSec;
        opVal = a_q.eRem;
      end
    end
    if (otpStart) a_d.otpB = 1'b1;
    if (otpLock) begin
      a_d.prot = 1'b1;
      a_d.fail = 1'b1;
    end
    if (otpDone) begin
      a_d.otpB = 1'b0;
      a_d.wel = 1'b0;
    end
    // write enable set wins over a clear in the same cycle
    if (doWren) a_d.wel = 1'b1;
  end

  // suspend state lives only here, flags reset to 80h
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      a_q <= ARR_RESET;
      rstSeen_q <= 1'b0;
    end else begin
      a_q <= a_d;
      rstSeen_q <= 1'b1;
    end
  end

  assign writeInProgress = a_q.act || a_q.otpB;
  assign writeEnableLatch = a_q.wel;
  assign readIndeterminate = a_q.rdInd;
  assign flagStatus = {!(a_q.act || a_q.otpB), a_q.flE, 1'b0, a_q.fail,
                       1'b0, a_q.flP, a_q.prot, 1'b0};

  // ------------------------------------------------------------------
  // serial command engine and otp storage
  // ------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    bit_d = bit_q;
    cmd_d = cmd_q;
    ab_d = ab_q;
    adr_d = adr_q;
    ptr_d = ptr_q;
    tx_d = tx_q;
    txc_d = txc_q;
    so_d = so_q;
    oe_d = oe_q;
    got_d = got_q;
    otp_d = otp_q;
    pd_d = pd_q;
    pm_d = pm_q;
    doWren = 1'b0;
    doSusp = 1'b0;
    doRes = 1'b0;
    otpStart = 1'b0;
    otpLock = 1'b0;
    // flash cells only go from 1 to 0, so merge by and
    if (otpDone) begin
      for (int i = 0; i < OTP_BYTES; i++) begin
        if (pm_q[i]) otp_d[i] = otp_q[i] & pd_q[i];
      end
    end
    if (!link.csActive) begin
      // single-byte commands and otp program act on rise
      if (link.csRise && bit_q == 3'h0) begin
        doWren = (st_q == ST_HELD) && (cmd_q == OP_WREN);
        doSusp = (st_q == ST_HELD) && (cmd_q == OP_SUSP);
        doRes = (st_q == ST_HELD) && (cmd_q == OP_RESUME);
        otpStart = (st_q == ST_WDATA) && got_q;
      end
      // select high stops output at once
      st_d = ST_CMD;
      bit_d = 3'h0;
      ab_d = 2'h0;
      txc_d = 3'h0;
      oe_d = 1'b0;
      got_d = 1'b0;
    end else if (link.sclkRise) begin
      // input sampled on rising link clock
      sh_d = {sh_q[6:0], link.din};
      bit_d = bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        case (st_q)
          ST_CMD: begin
            cmd_d = sh_d;
            case (sh_d)
              OP_WREN, OP_SUSP, OP_RESUME: st_d = ST_HELD;
              OP_RDOTP: st_d = ST_ADDR;
              OP_RDFSR: begin
                // flag status streamed, refreshed every byte
                st_d = ST_FSR;
                tx_d = flagStatus;
                oe_d = 1'b1;
              end
              OP_PGOTP: begin
                st_d = ST_SKIP;
                if (a_q.wel && !a_q.act && !a_q.otpB) begin
                  if (!otp_q[OTP_LAST][OTP_LOCK_BIT]) otpLock = 1'b1;
                  else begin
                    st_d = ST_ADDR;
                    pm_d = '0;
                  end
                end
              end
              default: st_d = ST_SKIP;
            endcase
          end
          ST_ADDR: begin
            adr_d = {adr_q[15:0], sh_d};
            ab_d = ab_q + 2'h1;
            if (ab_q == ADDR_LAST) begin
              ptr_d = clampPtr(adr_d);
              st_d = (cmd_q == OP_RDOTP) ? ST_DUMMY : ST_WDATA;
            end
          end
          ST_DUMMY: begin
            st_d = ST_OUT;
            tx_d = otp_q[ptr_q];
            ptr_d = clampPtr({17'h0, ptr_q} + 24'h1);
            oe_d = 1'b1;
          end
          ST_WDATA: begin
            got_d = 1'b1;
            // past the control byte data is dropped
            // pointer parks on the control byte; once that byte is
            // marked, every later byte falls through
            if (!pm_q[ptr_q]) begin
              pd_d[ptr_q] = sh_d;
              pm_d[ptr_q] = 1'b1;
              ptr_d = clampPtr({17'h0, ptr_q} + 24'h1);
            end
          end
          ST_HELD: st_d = ST_SKIP;
          default: st_d = st_q;
        endcase
      end
    end else if (link.sclkFall && (st_q == ST_OUT || st_q == ST_FSR)) begin
      // one bit per falling edge, msb first
      so_d = tx_q[3'h7 - txc_q];
      txc_d = txc_q + 3'h1;
      if (txc_q == 3'h7) begin
        if (st_q == ST_FSR) tx_d = flagStatus;
        else begin
          // address stops at the last location
          tx_d = otp_q[ptr_q];
          ptr_d = clampPtr({17'h0, ptr_q} + 24'h1);
        end
      end
    end
  end

  // otp contents reset erased: this model has no true retention
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_CMD;
      sh_q <= 8'h00;
      bit_q <= 3'h0;
      cmd_q <= 8'h00;
      ab_q <= 2'h0;
      adr_q <= 24'h000000;
      ptr_q <= 7'h00;
      tx_q <= 8'h00;
      txc_q <= 3'h0;
      so_q <= 1'b0;
      oe_q <= 1'b0;
      got_q <= 1'b0;
      otp_q <= '{default: OTP_ERASED};
      pd_q <= '{default: OTP_ERASED};
      pm_q <= '0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      cmd_q <= cmd_d;
      ab_q <= ab_d;
      adr_q <= adr_d;
      ptr_q <= ptr_d;
      tx_q <= tx_d;
      txc_q <= txc_d;
      so_q <= so_d;
      oe_q <= oe_d;
      got_q <= got_d;
      otp_q <= otp_d;
      pd_q <= pd_d;
      pm_q <= pm_d;
    end
  end

  assign serialOutputLine = so_q;
  assign serialOutputEn = oe_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  chk_psusp_flag: assert property (suspOk && !a_q.actE && !a_q.fin |=>
    flagStatus[FSR_PSUSP]) else $error("program suspend flag missing");
  chk_esusp_flag: assert property (suspOk && a_q.actE && !a_q.fin |=>
    flagStatus[FSR_ESUSP]) else $error("erase suspend flag missing");
  chk_ready_latency: assert property (latDone |=>
    flagStatus[FSR_READY] && !writeInProgress)
    else $error("not ready after suspend latency");
  chk_finish_clear: assert property (a_q.fin && !a_q.actE && opDone
    |=> !flagStatus[FSR_PSUSP]) else $error("finished op kept flag");
  chk_reset_flags: assert property (!rstSeen_q |->
    flagStatus == FSR_RESET) else $error("flag status not 80h at reset");
  chk_nest_order: assert property (resumeOk && a_q.pS && a_q.eS |=>
    a_q.act && !a_q.actE && a_q.eS) else $error("nested resume order");
  chk_block_prog: assert property (progBlock && !doWren |=>
    flagStatus[FSR_PFAIL] && $stable(writeEnableLatch))
    else $error("blocked program not flagged");
  chk_resume_busy: assert property (resumeOk |=>
    writeInProgress && !flagStatus[FSR_READY]) else $error("resume idle");
  chk_resume_ignore: assert property (doRes && !a_q.pS && !a_q.eS
    |=> $stable(flagStatus[FSR_ESUSP]) && !resumeOk)
    else $error("resume without suspend acted");
  chk_done_ready: assert property (opDone |=> flagStatus[FSR_READY])
    else $error("ready bit not restored");
  chk_ptr_clamp: assert property (ptr_q <= OTP_LAST)
    else $error("otp pointer beyond last location");
  chk_cs_stop: assert property (!link.csActive |=> !serialOutputEn)
    else $error("output kept after select high");
  chk_otp_busy: assert property (otpStart |=>
    writeInProgress && !flagStatus[FSR_READY]) else $error("otp idle");
  chk_otp_end: assert property (otpDone |=>
    !writeEnableLatch && !writeInProgress) else $error("otp end state");
  chk_otp_lock: assert property (otpLock |=> flagStatus[FSR_PROT] &&
    flagStatus[FSR_PFAIL] && writeEnableLatch) else $error("lock flags");
  chk_susp_idle: assert property (doSusp && !a_q.act && !arrayStart
    |=> $stable(flagStatus)) else $error("idle suspend changed flags");

  cov_nested: cover property (a_q.pS && a_q.eS);
  cov_finish: cover property (a_q.fin && opDone);
  cov_otp_prog: cover property (otpDone);
  cov_clamp_read: cover property (st_q == ST_OUT && ptr_q == OTP_LAST);
endmodule  // flash_suspend_otp
`default_nettype wire
